// File: fault_status_trigger_control.sv
/*
   Fault status group, error queue front, language select and trigger path.
   Assumes a same-clock command parser issuing one cmd per valid cycle,
   fault conditions and the stored language arriving on pins.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_status_trigger_control #(
   parameter int LEVEL_W = status_pkg::REG_W,
   parameter int QUEUE_DEPTH = status_pkg::ERR_DEPTH
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [15:0] fault_cond_in,
   input wire logic nv_lang_in,
   input wire logic cmd_valid,
   input wire status_pkg::cmd_t cmd,
   input wire logic err_push,
   input wire logic [15:0] err_code,
   output logic resp_valid,
   output status_pkg::resp_t resp,
   output logic [7:0] status_byte,
   output logic [15:0] op_status,
   output logic [LEVEL_W-1:0] imm_level,
   output logic [LEVEL_W-1:0] pend_level,
   output logic trigger_pulse,
   output status_pkg::lang_t lang_active,
   output logic nv_lang_wr,
   output status_pkg::lang_t nv_lang_data,
   output logic unit_reset
);
   logic [15:0] cond_meta;
   logic [15:0] cond_sync;
   logic [15:0] cond_reg;
   logic [15:0] cond_prev;
   logic [15:0] mask;
   logic [15:0] rise_filter;
   logic [15:0] fall_filter;
   logic [15:0] event_latch;
   logic [15:0] set_bits;
   logic [15:0] wr_hits;
   logic nv_meta;
   logic nv_sync;
   logic [1:0] boot_cnt;
   logic wait_flag;
   logic cont_arm;
   logic pend_set;
   logic in_range;
   logic lang_sw;
   logic trigger_ok;
   logic bad_write;
   logic bad_src;
   logic bad_trigger;
   logic q_push;
   logic [15:0] q_code;
   logic q_pop;
   logic [15:0] q_head;
   logic q_empty;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers, free of reset so strap value survives
   always_ff @(posedge core_clk) begin
      if (ce) begin
         cond_meta <= fault_cond_in;
         cond_sync <= cond_meta;
         nv_meta <= nv_lang_in;
         nv_sync <= nv_meta;
      end
   end

   // Live condition and its previous clock value
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cond_reg <= '0;
         cond_prev <= '0;
      end else if (ce) begin
         cond_reg <= cond_sync & status_pkg::COND_DEFINED;
         cond_prev <= cond_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Command decode
   always_comb begin
      in_range = (cmd.data <= status_pkg::REG_MAX);
      lang_sw = cmd_valid && (cmd.op == status_pkg::OP_LANG_SET);
      trigger_ok = cmd_valid && (cmd.op == status_pkg::OP_TRIGGER) && wait_flag;
      bad_trigger = cmd_valid && (cmd.op == status_pkg::OP_TRIGGER) && !wait_flag;
      bad_src = cmd_valid && (cmd.op == status_pkg::OP_SRC_SET) &&
                (cmd.data != 16'(status_pkg::SRC_BUS));
      bad_write = cmd_valid && !in_range && ((cmd.op == status_pkg::OP_WR_MASK) ||
                  (cmd.op == status_pkg::OP_WR_RISE) || (cmd.op == status_pkg::OP_WR_FALL));
      q_pop = cmd_valid && (cmd.op == status_pkg::OP_ERR_QUERY);
   end

   // Filter writes catch conditions already in the detected state
   always_comb begin
      wr_hits = '0;
      if (cmd_valid && in_range && cmd.op == status_pkg::OP_WR_RISE) begin
         wr_hits = cmd.data & cond_reg;
      end
      if (cmd_valid && in_range && cmd.op == status_pkg::OP_WR_FALL) begin
         wr_hits = cmd.data & ~cond_reg & status_pkg::COND_DEFINED;
      end
   end

   // Edge filters, both set means any change, both clear means none
   assign set_bits = (cond_reg & ~cond_prev & rise_filter) |
                     (~cond_reg & cond_prev & fall_filter) |
                     wr_hits;

   ////////////////////////////////////////////////////////////////////
   // Mask and filter registers
   always_ff @(posedge core_clk) begin
      if (sys_rst || (ce && lang_sw)) begin
         mask <= status_pkg::MASK_RESET;
         rise_filter <= status_pkg::FILTER_RESET;
         fall_filter <= status_pkg::FILTER_RESET;
      end else if (ce && cmd_valid && in_range) begin
         if (cmd.op == status_pkg::OP_WR_MASK) begin
            mask <= cmd.data;
         end
         if (cmd.op == status_pkg::OP_WR_RISE) begin
            rise_filter <= cmd.data;
         end
         if (cmd.op == status_pkg::OP_WR_FALL) begin
            fall_filter <= cmd.data;
         end
      end
   end

   // Event latch, new set bits survive a clearing read
   always_ff @(posedge core_clk) begin
      if (sys_rst || (ce && lang_sw)) begin
         event_latch <= status_pkg::EVENT_RESET;
      end else if (ce) begin
         if (cmd_valid && cmd.op == status_pkg::OP_RD_EVENT) begin
            event_latch <= set_bits;
         end else begin
            event_latch <= event_latch | set_bits;
         end
      end
   end

   // Status byte carries the masked event summary
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         status_byte <= '0;
      end else if (ce) begin
         status_byte <= '0;
         status_byte[status_pkg::SUMMARY_BIT] <= |(event_latch & mask);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Error sources merged into one queue push, own errors first
   always_comb begin
      q_push = 1'b1;
      q_code = err_code;
      if (bad_write) begin
         q_code = status_pkg::ERR_RANGE;
      end else if (bad_src) begin
         q_code = status_pkg::ERR_PARAM;
      end else if (bad_trigger) begin
         q_code = status_pkg::ERR_TRIGGER_IGNORED;
      end else begin
         q_push = err_push;
      end
   end

   err_queue #(
      .DEPTH(QUEUE_DEPTH),
      .W(status_pkg::REG_W)
   ) u_err_queue (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .clear(lang_sw),
      .push(q_push),
      .push_code(q_code),
      .pop(q_pop),
      .head_code(q_head),
      .empty(q_empty)
   );

   ////////////////////////////////////////////////////////////////////
   // Language select, loaded from the stored copy after reset
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         boot_cnt <= status_pkg::BOOT_CYCLES;
         lang_active <= status_pkg::LANG_NATIVE;
         nv_lang_wr <= 1'b0;
         nv_lang_data <= status_pkg::LANG_NATIVE;
         unit_reset <= 1'b0;
      end else if (ce) begin
         nv_lang_wr <= 1'b0;
         unit_reset <= 1'b0;
         if (boot_cnt != '0) begin
            boot_cnt <= boot_cnt - 2'h1;
            lang_active <= status_pkg::lang_t'(nv_sync);
         end else if (lang_sw) begin
            lang_active <= status_pkg::lang_t'(cmd.data[0]);
            nv_lang_data <= status_pkg::lang_t'(cmd.data[0]);
            nv_lang_wr <= 1'b1;
            unit_reset <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Trigger arming and wait flag
   always_ff @(posedge core_clk) begin
      if (sys_rst || (ce && lang_sw)) begin
         wait_flag <= 1'b0;
         cont_arm <= 1'b0;
         trigger_pulse <= 1'b0;
      end else if (ce) begin
         trigger_pulse <= trigger_ok;
         if (cmd_valid && cmd.op == status_pkg::OP_CONT_ARM) begin
            cont_arm <= cmd.data[0];
            wait_flag <= wait_flag | cmd.data[0];
         end else if (cmd_valid && cmd.op == status_pkg::OP_ARM) begin
            wait_flag <= 1'b1;
         end else if (trigger_ok) begin
            wait_flag <= cont_arm;
         end
      end
   end

   // Operation status shows the wait flag
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         op_status <= '0;
      end else if (ce) begin
         op_status <= '0;
         op_status[status_pkg::WAIT_BIT] <= wait_flag;
      end
   end

   // Immediate and pending output levels
   always_ff @(posedge core_clk) begin
      if (sys_rst || (ce && lang_sw)) begin
         imm_level <= LEVEL_W'(status_pkg::LEVEL_RESET);
         pend_level <= LEVEL_W'(status_pkg::LEVEL_RESET);
         pend_set <= 1'b0;
      end else if (ce) begin
         if (trigger_ok) begin
            imm_level <= pend_level;
         end else if (cmd_valid && cmd.op == status_pkg::OP_WR_IMM) begin
            imm_level <= LEVEL_W'(cmd.data);
            if (!pend_set) begin
               pend_level <= LEVEL_W'(cmd.data);
            end
         end else if (cmd_valid && cmd.op == status_pkg::OP_WR_PEND) begin
            pend_level <= LEVEL_W'(cmd.data);
            pend_set <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Answers, one cycle after each command
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         resp_valid <= 1'b0;
         resp <= '0;
      end else if (ce) begin
         resp_valid <= cmd_valid;
         resp.msg <= status_pkg::MSG_DATA;
         resp.data <= '0;
         unique case (cmd.op)
            status_pkg::OP_RD_COND: resp.data <= cond_reg;
            status_pkg::OP_RD_EVENT: resp.data <= event_latch;
            status_pkg::OP_RD_MASK: resp.data <= mask;
            status_pkg::OP_RD_RISE: resp.data <= rise_filter;
            status_pkg::OP_RD_FALL: resp.data <= fall_filter;
            status_pkg::OP_LANG_RD: resp.data <= 16'(lang_active);
            status_pkg::OP_SRC_RD: resp.data <= 16'(status_pkg::SRC_BUS);
            status_pkg::OP_RD_IMM: resp.data <= 16'(imm_level);
            status_pkg::OP_RD_PEND: resp.data <= 16'(pend_level);
            status_pkg::OP_ERR_QUERY: begin
               if (q_empty) begin
                  resp.data <= status_pkg::ERR_NONE;
                  resp.msg <= status_pkg::MSG_NO_ERROR;
               end else begin
                  resp.data <= q_head;
                  resp.msg <= (q_head == status_pkg::ERR_OVERFLOW) ?
                              status_pkg::MSG_TOO_MANY : status_pkg::MSG_QUEUED;
               end
            end
            default: resp.data <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   property p_cond_read_only;
      @(posedge core_clk) disable iff (sys_rst)
      ce && cmd_valid |=> cond_reg == ($past(cond_sync) & status_pkg::COND_DEFINED);
   endproperty
   a_cond_read_only: assert property (p_cond_read_only) else $error("condition not live");

   property p_summary;
      @(posedge core_clk) disable iff (sys_rst)
      ce |=> status_byte[status_pkg::SUMMARY_BIT] == |($past(event_latch) & $past(mask));
   endproperty
   a_summary: assert property (p_summary) else $error("summary bit wrong");

   property p_rise_edge;
      @(posedge core_clk) disable iff (sys_rst)
      ce && !lang_sw && (cond_reg & ~cond_prev & rise_filter) != '0
         |=> (event_latch & $past(cond_reg & ~cond_prev & rise_filter)) ==
             $past(cond_reg & ~cond_prev & rise_filter);
   endproperty
   a_rise_edge: assert property (p_rise_edge) else $error("rising edge lost");

   property p_fall_edge;
      @(posedge core_clk) disable iff (sys_rst)
      ce && !lang_sw && (~cond_reg & cond_prev & fall_filter) != '0
         |=> (event_latch & $past(~cond_reg & cond_prev & fall_filter)) != '0;
   endproperty
   a_fall_edge: assert property (p_fall_edge) else $error("falling edge lost");

   property p_no_filter;
      @(posedge core_clk) disable iff (sys_rst)
      ce && cmd_valid && cmd.op == status_pkg::OP_RD_EVENT &&
      !wr_hits[status_pkg::OVERTEMP_BIT] && !rise_filter[status_pkg::OVERTEMP_BIT] &&
      !fall_filter[status_pkg::OVERTEMP_BIT]
         |=> !event_latch[status_pkg::OVERTEMP_BIT];
   endproperty
   a_no_filter: assert property (p_no_filter) else $error("unfiltered event set");

   property p_trigger_moves;
      @(posedge core_clk) disable iff (sys_rst)
      ce && trigger_ok && !lang_sw |=> imm_level == $past(pend_level) && trigger_pulse;
   endproperty
   a_trigger_moves: assert property (p_trigger_moves) else $error("level not moved");

   property p_wait_clear;
      @(posedge core_clk) disable iff (sys_rst)
      ce && trigger_ok |=> op_status[status_pkg::WAIT_BIT] ##1
         (op_status[status_pkg::WAIT_BIT] == $past(cont_arm, 2));
   endproperty
   a_wait_clear: assert property (p_wait_clear) else $error("wait flag wrong after trigger");

   property p_pend_hold;
      @(posedge core_clk) disable iff (sys_rst)
      ce && pend_set && cmd_valid && cmd.op == status_pkg::OP_WR_IMM && !lang_sw
         |=> pend_level == $past(pend_level);
   endproperty
   a_pend_hold: assert property (p_pend_hold) else $error("pending level overwritten");

   property p_empty_answer;
      @(posedge core_clk) disable iff (sys_rst)
      ce && q_pop && q_empty |=> resp_valid && resp.data == status_pkg::ERR_NONE &&
         resp.msg == status_pkg::MSG_NO_ERROR;
   endproperty
   a_empty_answer: assert property (p_empty_answer) else $error("empty query answer wrong");

   property p_lang_switch;
      @(posedge core_clk) disable iff (sys_rst)
      ce && lang_sw && boot_cnt == '0 |=> nv_lang_wr && unit_reset && event_latch == '0 &&
         nv_lang_data == lang_active;
   endproperty
   a_lang_switch: assert property (p_lang_switch) else $error("language switch incomplete");
endmodule : fault_status_trigger_control
`default_nettype wire

// File: status_pkg.sv
/*
   Shared constants, command and answer types for the fault status,
   error queue, language select and trigger block.
   Assumes one 100 MHz clock and a command parser on the same clock.
*/
// Behaviour
// - Condition register is live, read only
// - Status byte bit 3 ORs enabled events
// - Summary mask read/write, 0..32727, resets 0
// - Event latch read only, cleared by read
// - Falling filter catches one-to-zero changes
// - Rising filter catches zero-to-one changes
// - Both filters set catch any change
// - Both filters clear never set event
// - Filter write sets event for present state
// - Rise and fall filters read/write, reset 0
// - Errors queue first-in first-out, popped on query
// - Empty queue answers code 0, no error
// - Overflow makes last entry code -350
// - Language switch stores, resets, clears queues
// - Power-up language is the stored one
// - Armed trigger moves pending level to immediate
// - Accepted trigger clears the wait flag
// - Continuous arming re-arms right after trigger
// - Trigger source is bus only, reset bus
// - Immediate write also sets unprogrammed pending level
// - Programmed pending level ignores immediate writes
// - Wait flag sits at operation bit 5
// - Fault bits 0,1,4,9,10 placed as defined
`default_nettype none
package status_pkg;

   localparam int REG_W = 16;
   localparam logic [15:0] REG_MAX = 16'h7fd7;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [15:0] FILTER_RESET = 16'h0000;
   localparam logic [15:0] EVENT_RESET = 16'h0000;
   localparam logic [15:0] LEVEL_RESET = 16'h0000;

   // Fault bit positions
   localparam int OVERVOLT_BIT = 0;
   localparam int OVERCURRENT_BIT = 1;
   localparam int OVERTEMP_BIT = 4;
   localparam int INHIBIT_BIT = 9;
   localparam int UNREGULATED_BIT = 10;
   localparam logic [15:0] COND_DEFINED = 16'h0613;

   localparam int SUMMARY_BIT = 3;
   localparam int WAIT_BIT = 5;

   // Error codes, two's complement
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] ERR_OVERFLOW = 16'hfea2;
   localparam logic [15:0] ERR_RANGE = 16'hff22;
   localparam logic [15:0] ERR_PARAM = 16'hff20;
   localparam logic [15:0] ERR_TRIGGER_IGNORED = 16'hff2d;
   localparam int ERR_DEPTH = 8;

   localparam logic [1:0] BOOT_CYCLES = 2'h3;

   typedef enum logic {LANG_NATIVE, LANG_COMPAT} lang_t;
   typedef enum logic {SRC_BUS} trigger_src_t;

   typedef enum logic [4:0] {
      OP_RD_COND, OP_RD_EVENT, OP_RD_MASK, OP_WR_MASK, OP_RD_RISE, OP_WR_RISE,
      OP_RD_FALL, OP_WR_FALL, OP_ERR_QUERY, OP_LANG_SET, OP_LANG_RD, OP_ARM,
      OP_CONT_ARM, OP_TRIGGER, OP_SRC_SET, OP_SRC_RD, OP_WR_IMM, OP_WR_PEND,
      OP_RD_IMM, OP_RD_PEND
   } op_t;

   typedef enum logic [1:0] {MSG_DATA, MSG_NO_ERROR, MSG_QUEUED, MSG_TOO_MANY} msg_t;

   typedef struct packed {
      op_t op;
      logic [15:0] data;
   } cmd_t;

   typedef struct packed {
      msg_t msg;
      logic [15:0] data;
   } resp_t;

endpackage : status_pkg
`default_nettype wire

// File: err_queue.sv
/*
   First-in first-out error queue with overflow marker.
   Assumes push and pop come from logic on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module err_queue #(
   parameter int DEPTH = status_pkg::ERR_DEPTH,
   parameter int W = status_pkg::REG_W
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic clear,
   input wire logic push,
   input wire logic [W-1:0] push_code,
   input wire logic pop,
   output logic [W-1:0] head_code,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] store [DEPTH];
   logic [AW-1:0] rd_ptr;
   logic [AW-1:0] wr_ptr;
   logic [AW:0] count;
   logic do_pop;
   logic do_push;
   logic [W-1:0] wr_code;

   ////////////////////////////////////////////////////////////////////
   // Last free slot takes the overflow marker, further pushes dropped
   assign do_pop = pop && (count != '0);
   assign do_push = push && (count < (AW+1)'(DEPTH)) &&
                    !((count == (AW+1)'(DEPTH)) && !do_pop);
   assign wr_code = (count >= (AW+1)'(DEPTH - 1)) ? status_pkg::ERR_OVERFLOW : push_code;
   assign head_code = store[rd_ptr];
   assign empty = (count == '0);

   // Storage write
   always_ff @(posedge core_clk) begin
      if (ce && do_push && !clear && !sys_rst) begin
         store[wr_ptr] <= wr_code;
      end
   end

   // Pointers and fill count
   always_ff @(posedge core_clk) begin
      if (sys_rst || (ce && clear)) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count <= '0;
      end else if (ce) begin
         if (do_push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (do_pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   property p_no_overfill;
      @(posedge core_clk) disable iff (sys_rst)
      count <= (AW+1)'(DEPTH);
   endproperty
   a_no_overfill: assert property (p_no_overfill) else $error("queue count above depth");

   property p_full_marker;
      @(posedge core_clk) disable iff (sys_rst)
      (ce && !clear && push && !do_pop && count == (AW+1)'(DEPTH - 1))
         |=> store[$past(wr_ptr)] == status_pkg::ERR_OVERFLOW;
   endproperty
   a_full_marker: assert property (p_full_marker) else $error("last entry not overflow");
endmodule : err_queue
`default_nettype wire

// File: fstc_host.sv
/*
   Command host model for the fault status block.
   Assumes the block takes a command at the edge where cmd_valid is high.
*/
`timescale 1ns/1ps
`default_nettype none
module fstc_host (
   input wire logic core_clk,
   output logic cmd_valid,
   output status_pkg::cmd_t cmd,
   input wire logic resp_valid,
   input wire status_pkg::resp_t resp
);
   ////////////////////////////////////////
   // Idle command lines
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end

   // One command, answer taken just after the accepting edge
   task automatic issue(input status_pkg::op_t op, input logic [15:0] d,
      output logic v, output status_pkg::resp_t r);
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b1;
      cmd.op = op;
      cmd.data = d;
      @(posedge core_clk);
      #1;
      v = resp_valid;
      r = resp;
      cmd_valid = 1'b0;
      cmd.data = ~d; // Stale data value never left on the data lines
   endtask : issue
endmodule : fstc_host
`default_nettype wire

// File: fault_status_trigger_control_test.sv
/*
   Self-checking bench for the fault status and trigger block.
   Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_status_trigger_control_test;
   logic core_clk, sys_rst, ce, nv_lang_in, err_push, cmd_valid, resp_valid, v;
   logic trigger_pulse, nv_lang_wr, unit_reset;
   logic [15:0] fault_cond_in, err_code, op_status, imm_level, pend_level;
   logic [7:0] status_byte;
   status_pkg::cmd_t cmd;
   status_pkg::resp_t resp, r;
   status_pkg::lang_t lang_active, nv_lang_data;
   int n_fail = 0;
   int comparisons = 0;
   logic [17:0] q_exp [9];

   fault_status_trigger_control dut (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce),
      .fault_cond_in(fault_cond_in), .nv_lang_in(nv_lang_in), .cmd_valid(cmd_valid),
      .cmd(cmd), .err_push(err_push), .err_code(err_code), .resp_valid(resp_valid),
      .resp(resp), .status_byte(status_byte), .op_status(op_status),
      .imm_level(imm_level), .pend_level(pend_level), .trigger_pulse(trigger_pulse),
      .lang_active(lang_active), .nv_lang_wr(nv_lang_wr), .nv_lang_data(nv_lang_data),
      .unit_reset(unit_reset));
   fstc_host host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd(cmd),
      .resp_valid(resp_valid), .resp(resp));

   ////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Command with answer check
   task automatic cc(input status_pkg::op_t op, input logic [15:0] d, input logic [17:0] e);
      host.issue(op, d, v, r);
      chk({17'h0, v}, 18'h1);
      chk(r, e);
   endtask : cc

   // Idle cycles, inputs change just after the edge
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wt

   // Parser error pulse
   task automatic ep(input logic [15:0] c);
      @(posedge core_clk);
      #1;
      err_push = 1'b1;
      err_code = c;
      @(posedge core_clk);
      #1;
      err_push = 1'b0;
   endtask : ep

   // Verdict and end of run
   task automatic complete_run;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Hang guard, some ten times the expected run
   initial begin
      #20000;
      n_fail++;
      complete_run;
   end

   // Main sequence
   initial begin
      q_exp = '{{status_pkg::MSG_QUEUED, status_pkg::ERR_RANGE},
         {status_pkg::MSG_QUEUED, status_pkg::ERR_TRIGGER_IGNORED},
         {status_pkg::MSG_QUEUED, status_pkg::ERR_PARAM},
         {status_pkg::MSG_QUEUED, 16'h0001}, {status_pkg::MSG_QUEUED, 16'h0002},
         {status_pkg::MSG_QUEUED, 16'h0003}, {status_pkg::MSG_QUEUED, 16'h0004},
         {status_pkg::MSG_TOO_MANY, status_pkg::ERR_OVERFLOW},
         {status_pkg::MSG_NO_ERROR, status_pkg::ERR_NONE}};
      ce = 1'b1;
      sys_rst = 1'b1;
      nv_lang_in = 1'b1;
      err_push = 1'b0;
      err_code = 16'h0000;
      fault_cond_in = 16'h0000;
      wt(10);
      sys_rst = 1'b0;
      wt(4);
      chk({17'h0, lang_active}, {17'h0, status_pkg::LANG_COMPAT});
      cc(status_pkg::OP_LANG_RD, 16'h0, 18'h00001);
      cc(status_pkg::OP_RD_MASK, 16'h0, 18'h0);
      cc(status_pkg::OP_RD_RISE, 16'h0, 18'h0);
      cc(status_pkg::OP_RD_FALL, 16'h0, 18'h0);
      cc(status_pkg::OP_SRC_SET, 16'h0, 18'h0);
      cc(status_pkg::OP_SRC_RD, 16'h0, 18'h0);
      // Live condition, defined bits only, no filters
      fault_cond_in = 16'hffff;
      wt(6);
      cc(status_pkg::OP_RD_COND, 16'h0, 18'h00613);
      cc(status_pkg::OP_RD_EVENT, 16'h0, 18'h0);
      fault_cond_in = 16'h0000;
      wt(6);
      // Bit 0 rise, bit 1 fall, bit 4 both, bit 9 neither
      cc(status_pkg::OP_WR_RISE, 16'h0011, 18'h0);
      cc(status_pkg::OP_WR_FALL, 16'h0012, 18'h0);
      cc(status_pkg::OP_RD_FALL, 16'h0, 18'h00012);
      cc(status_pkg::OP_RD_EVENT, 16'h0, 18'h00012);
      fault_cond_in = 16'h0213;
      wt(6);
      cc(status_pkg::OP_RD_EVENT, 16'h0, 18'h00011);
      fault_cond_in = 16'h0000;
      wt(6);
      cc(status_pkg::OP_RD_EVENT, 16'h0, 18'h00012);
      cc(status_pkg::OP_RD_EVENT, 16'h0, 18'h0);
      fault_cond_in = 16'h0200;
      wt(6);
      cc(status_pkg::OP_RD_EVENT, 16'h0, 18'h0);
      // Filter write on a bit already high, summary follows
      cc(status_pkg::OP_WR_MASK, 16'h0200, 18'h0);
      cc(status_pkg::OP_WR_RISE, 16'h0211, 18'h0);
      wt(1);
      chk({10'h0, status_byte}, 18'h8);
      cc(status_pkg::OP_RD_EVENT, 16'h0, 18'h00200);
      wt(1);
      chk({10'h0, status_byte}, 18'h0);
      // Mask bounds and refused commands feed the queue
      cc(status_pkg::OP_WR_MASK, 16'h7fd7, 18'h0);
      cc(status_pkg::OP_WR_MASK, 16'h7fd8, 18'h0);
      cc(status_pkg::OP_RD_MASK, 16'h0, 18'h07fd7);
      cc(status_pkg::OP_TRIGGER, 16'h0, 18'h0);
      cc(status_pkg::OP_SRC_SET, 16'h1, 18'h0);
      for (int k = 1; k <= 5; k++) ep(16'(k));
      for (int i = 0; i < 9; i++) cc(status_pkg::OP_ERR_QUERY, 16'h0, q_exp[i]);
      // Immediate and pending levels
      cc(status_pkg::OP_WR_IMM, 16'h0005, 18'h0);
      cc(status_pkg::OP_RD_PEND, 16'h0, 18'h00005);
      cc(status_pkg::OP_WR_PEND, 16'h0009, 18'h0);
      cc(status_pkg::OP_WR_IMM, 16'h0007, 18'h0);
      cc(status_pkg::OP_RD_PEND, 16'h0, 18'h00009);
      cc(status_pkg::OP_RD_IMM, 16'h0, 18'h00007);
      chk({2'h0, imm_level}, 18'h00007);
      chk({2'h0, pend_level}, 18'h00009);
      // Single arm then trigger
      cc(status_pkg::OP_ARM, 16'h0, 18'h0);
      wt(1);
      chk({2'h0, op_status}, 18'h00020);
      cc(status_pkg::OP_TRIGGER, 16'h0, 18'h0);
      chk({2'h0, imm_level}, 18'h00009);
      chk({17'h0, trigger_pulse}, 18'h1);
      wt(1);
      chk({2'h0, op_status}, 18'h0);
      // Continuous arming keeps the wait flag up
      cc(status_pkg::OP_CONT_ARM, 16'h1, 18'h0);
      wt(1);
      cc(status_pkg::OP_TRIGGER, 16'h0, 18'h0);
      chk({17'h0, trigger_pulse}, 18'h1);
      for (int i = 0; i < 3; i++) begin
         chk({2'h0, op_status}, 18'h00020);
         wt(1);
      end
      // Language switch stores, resets and clears
      cc(status_pkg::OP_LANG_SET, 16'h0, 18'h0);
      chk({16'h0, lang_active, nv_lang_data}, 18'h0);
      chk({16'h0, nv_lang_wr, unit_reset}, 18'h3);
      wt(20);
      chk({2'h0, op_status}, 18'h0);
      cc(status_pkg::OP_RD_MASK, 16'h0, 18'h0);
      cc(status_pkg::OP_RD_PEND, 16'h0, 18'h0);
      cc(status_pkg::OP_ERR_QUERY, 16'h0, {status_pkg::MSG_NO_ERROR, 16'h0});
      // Switch back to the compatibility language
      cc(status_pkg::OP_LANG_SET, 16'h1, 18'h0);
      chk({16'h0, lang_active, nv_lang_data}, 18'h3);
      chk({16'h0, nv_lang_wr, unit_reset}, 18'h3);
      wt(20);
      cc(status_pkg::OP_LANG_RD, 16'h0, 18'h00001);
      complete_run;
   end
endmodule : fault_status_trigger_control_test
`default_nettype wire
